//--- logic/power_source_and_mode_sequencer.sv
// power source selection, regulator sequencing and power mode control
// assumes ref_clk is the never-stopping timer oscillator; core writes are same-domain
`timescale 1ns/100ps
`default_nettype none
module power_source_and_mode_sequencer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic external_reset_pin,
  input wire logic wake_pin,
  input wire power_seq_pkg::monitor_t monitorIn,
  input wire power_seq_pkg::wake_src_t wakeSrc,
  input wire power_seq_pkg::power_ctrl_t powerCtrl,
  input wire logic powerCtrlWrite,
  input wire logic offRequest,
  input wire logic [power_seq_pkg::ANA_PERIPH-1:0] analogPowerDownIn,
  input wire logic analogPowerDownWrite,
  input wire logic retentionWrite,
  input wire logic [2:0] retentionIndex,
  input wire logic [power_seq_pkg::RET_W-1:0] retentionData,
  input wire logic flagClear,
  output power_seq_pkg::power_out_t powerOut,
  output power_seq_pkg::mode_t mode,
  output logic deep_powerdown_flag,
  output logic sleepFlag,
  output logic systemPowerOnReset,
  output logic bootEnable,
  output logic brownoutIrq,
  output logic timerOscEnable,
  output logic [power_seq_pkg::ANA_PERIPH-1:0] analogPowerDown,
  output logic [power_seq_pkg::RET_W-1:0] retentionOut
);
  localparam int NSYNC = 11;

  typedef struct packed {
    power_seq_pkg::mode_t mode;
    logic [power_seq_pkg::CNT_W-1:0] count;
    logic [power_seq_pkg::CNT_W-1:0] wakeLow;
    logic armed;
    logic resetPinLast;
    logic [1:0] modeReq;
    logic autoSwitchOff;
    logic batteryOverride;
    logic brownoutEnable;
    logic fieldWakeEnable;
    logic wakePinEnable;
    logic dpdFlag;
    logic sleepFlag;
    logic sysPor;
    logic boot;
    logic brownout;
    logic batterySwitch;
    logic fieldSwitch;
    logic [power_seq_pkg::ANA_PERIPH-1:0] analogPd;
    logic [4:0][power_seq_pkg::RET_W-1:0] retention;
    logic [power_seq_pkg::RET_W-1:0] retRead;
  } seq_state_t;

  seq_state_t state_reg;
  seq_state_t state_next;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;
  logic rstPin;
  logic wakeP;
  logic batOk;
  logic fldOk;
  logic fldPres;
  logic aonLow;
  logic oscOk;
  logic flashOk;
  logic timerEv;
  logic wdogEv;
  logic startEv;
  logic resetEdge;
  logic wakePinHeld;
  logic anyPower;
  logic wakeDeepSleep;
  logic wakeDeepPd;

  // -----------------------------
  // input synchronisers
  // -----------------------------
  assign rawIn = {external_reset_pin, wake_pin, monitorIn.batteryAbove, monitorIn.fieldAbove,
                  monitorIn.fieldPresent, monitorIn.alwaysOnLow, monitorIn.systemOscStable,
                  monitorIn.flashReady, wakeSrc.timerPreset, wakeSrc.watchdog,
                  wakeSrc.startLogic};

  sync_two_ff #(.WIDTH(NSYNC)) inSync (
    .ref_clk(ref_clk),
    .reset(reset),
    .resetValue({2'h3, 9'h000}), // pins idle high, so no false edge after reset
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  assign {rstPin, wakeP, batOk, fldOk, fldPres, aonLow, oscOk, flashOk, timerEv, wdogEv,
          startEv} = syncIn;

  // wake and trigger decode
  assign resetEdge = rstPin && !state_reg.resetPinLast;
  assign wakePinHeld = state_reg.wakeLow >= power_seq_pkg::CNT_W'(power_seq_pkg::WAKE_LOW_CYCLES);
  assign wakeDeepSleep = !rstPin || timerEv || wdogEv || wakePinHeld ||
                         (fldPres && state_reg.fieldWakeEnable) || startEv;
  assign wakeDeepPd = !rstPin || timerEv || (wakePinHeld && state_reg.wakePinEnable) ||
                      (fldPres && state_reg.fieldWakeEnable);
  assign anyPower = state_reg.batterySwitch || state_reg.fieldSwitch;

  // -----------------------------
  // next state
  // -----------------------------
  always_comb begin
    state_next = state_reg;
    state_next.resetPinLast = rstPin;
    state_next.wakeLow = wakeP ? '0 :
      (wakePinHeld ? state_reg.wakeLow : state_reg.wakeLow + 1'b1);
    // control register writes
    if (powerCtrlWrite) begin
      state_next.modeReq = powerCtrl.modeReq;
      state_next.autoSwitchOff = powerCtrl.autoSwitchOff;
      state_next.batteryOverride = powerCtrl.batteryOverride;
      state_next.brownoutEnable = powerCtrl.brownoutEnable;
      state_next.fieldWakeEnable = powerCtrl.fieldWakeEnable;
      state_next.wakePinEnable = powerCtrl.wakePinEnable;
    end
    if (analogPowerDownWrite) begin
      state_next.analogPd = analogPowerDownIn;
    end
    if (retentionWrite && retentionIndex < 3'h5) begin
      state_next.retention[retentionIndex] = retentionData;
    end
    // registered read port, unused indices read as zero
    state_next.retRead = (retentionIndex < 3'h5) ? state_reg.retention[retentionIndex] : '0;
    // trigger arms the battery switch
    if (resetEdge || fldPres) begin
      state_next.armed = 1'b1;
    end
    // source selection
    state_next.fieldSwitch = fldPres;
    if (state_reg.autoSwitchOff) begin
      state_next.batterySwitch = state_next.armed && !state_reg.batteryOverride;
    end else begin
      state_next.batterySwitch = state_next.armed && batOk && !state_reg.batteryOverride;
      if (!batOk && fldOk) begin
        state_next.batterySwitch = 1'b0;
      end
    end
    if (offRequest && !fldPres) begin
      state_next.armed = 1'b0;
      state_next.batterySwitch = 1'b0;
    end
    // brownout flag, set wins over clear
    if (flagClear) begin
      state_next.brownout = 1'b0;
      state_next.dpdFlag = 1'b0;
      state_next.sleepFlag = 1'b0;
    end
    if (state_reg.brownoutEnable && aonLow && anyPower) begin
      state_next.brownout = 1'b1;
    end
    // mode machine
    state_next.count = state_reg.count + 1'b1;
    case (state_reg.mode)
      power_seq_pkg::BATTERY_OFF: begin
        state_next.count = '0;
        state_next.sysPor = 1'b0;
        state_next.boot = 1'b0;
        if (anyPower) begin
          state_next.mode = power_seq_pkg::SEQ_DIGITAL;
        end
      end
      power_seq_pkg::SEQ_DIGITAL: begin
        if (state_reg.count >= power_seq_pkg::CNT_W'(power_seq_pkg::DIG_SETTLE_CYCLES)) begin
          state_next.mode = power_seq_pkg::SEQ_ANALOG;
          state_next.count = '0;
        end
      end
      power_seq_pkg::SEQ_ANALOG: begin
        if (oscOk) begin
          state_next.sysPor = 1'b1;
        end
        if (state_reg.count >= power_seq_pkg::CNT_W'(power_seq_pkg::ANA_SETTLE_CYCLES)) begin
          state_next.mode = power_seq_pkg::SEQ_BOOT;
        end
      end
      power_seq_pkg::SEQ_BOOT: begin
        if (oscOk) begin
          state_next.sysPor = 1'b1;
        end
        if (flashOk && state_reg.sysPor) begin
          state_next.mode = power_seq_pkg::ACTIVE;
          state_next.boot = 1'b1;
        end
      end
      power_seq_pkg::ACTIVE: begin
        case (state_reg.modeReq)
          power_seq_pkg::REQ_SLEEP: begin
            state_next.mode = power_seq_pkg::SLEEP;
            state_next.sleepFlag = 1'b1;
          end
          power_seq_pkg::REQ_DEEP_SLEEP: begin
            state_next.mode = power_seq_pkg::DEEP_SLEEP;
            state_next.sleepFlag = 1'b1;
          end
          power_seq_pkg::REQ_DEEP_PD: begin
            state_next.mode = power_seq_pkg::DEEP_PD;
            state_next.dpdFlag = 1'b1;
            state_next.boot = 1'b0;
            state_next.sysPor = 1'b0;
          end
          default: begin
          end
        endcase
        if (!powerCtrlWrite) begin
          state_next.modeReq = power_seq_pkg::REQ_NONE; // keep a request written now
        end
      end
      power_seq_pkg::SLEEP: begin
        if (wakeDeepSleep) begin
          state_next.mode = power_seq_pkg::ACTIVE;
        end
      end
      power_seq_pkg::DEEP_SLEEP: begin
        if (wakeDeepSleep) begin
          state_next.mode = power_seq_pkg::ACTIVE;
        end
      end
      power_seq_pkg::DEEP_PD: begin
        state_next.count = '0;
        if (wakeDeepPd) begin
          state_next.mode = power_seq_pkg::SEQ_DIGITAL;
        end
      end
      default: begin
        state_next.mode = power_seq_pkg::BATTERY_OFF;
      end
    endcase
    // losing every source drops to battery-off unless the reset pin is low outside battery-off and deep power-down
    if (!state_next.batterySwitch && !state_next.fieldSwitch) begin
      state_next.mode = power_seq_pkg::BATTERY_OFF;
    end
    // reset pin low restarts the sequence from the digital state
    if (!rstPin && state_reg.mode != power_seq_pkg::BATTERY_OFF &&
        state_reg.mode != power_seq_pkg::DEEP_PD) begin
      state_next.mode = power_seq_pkg::SEQ_DIGITAL;
      state_next.count = '0;
      state_next.sysPor = 1'b0;
      state_next.boot = 1'b0;
    end
  end

  // state register; retention survives all but the power-on reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.mode <= power_seq_pkg::BATTERY_OFF;
      state_reg.resetPinLast <= 1'b1;
      state_reg.analogPd <= power_seq_pkg::PD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------
  // outputs
  // -----------------------------
  assign mode = state_reg.mode;
  assign powerOut.batteryPowerSwitch = state_reg.batterySwitch;
  assign powerOut.fieldPowerSwitch = state_reg.fieldSwitch;
  assign powerOut.alwaysOnDomain = state_reg.mode != power_seq_pkg::BATTERY_OFF;
  assign powerOut.digitalRegulator = state_reg.mode != power_seq_pkg::BATTERY_OFF &&
                                     state_reg.mode != power_seq_pkg::DEEP_PD;
  assign powerOut.analogRegulator = powerOut.digitalRegulator &&
                                    state_reg.mode != power_seq_pkg::SEQ_DIGITAL;
  assign powerOut.comparatorEnable = !state_reg.autoSwitchOff;
  assign deep_powerdown_flag = state_reg.dpdFlag;
  assign sleepFlag = state_reg.sleepFlag;
  assign systemPowerOnReset = state_reg.sysPor;
  assign bootEnable = state_reg.boot;
  assign brownoutIrq = state_reg.brownout;
  assign timerOscEnable = 1'b1;
  assign analogPowerDown = state_reg.analogPd;
  assign retentionOut = state_reg.retRead;

  // -----------------------------
  // assertions
  // -----------------------------
  field_switch_a: assert property (@(posedge ref_clk) disable iff (reset)
    fldPres |=> powerOut.fieldPowerSwitch) else $error("field switch not closed");
  battery_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !state_reg.armed |-> !powerOut.batteryPowerSwitch) else $error("battery switch early");
  auto_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.autoSwitchOff |-> !powerOut.comparatorEnable) else $error("comparator on");
  seq_first_a: assert property (@(posedge ref_clk) disable iff (reset)
    mode == power_seq_pkg::SEQ_DIGITAL |-> powerOut.digitalRegulator && !powerOut.analogRegulator)
    else $error("bad first state");
  dpd_regs_a: assert property (@(posedge ref_clk) disable iff (reset)
    mode == power_seq_pkg::DEEP_PD |-> !powerOut.digitalRegulator && deep_powerdown_flag)
    else $error("deep power-down encoding");
  boot_flash_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(bootEnable) |-> $past(flashOk) && systemPowerOnReset) else $error("boot early");
  brownout_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.brownoutEnable && aonLow && anyPower |=> brownoutIrq) else $error("no brownout");
  timer_osc_a: assert property (@(posedge ref_clk) disable iff (reset)
    timerOscEnable) else $error("timer oscillator off");
endmodule // power_source_and_mode_sequencer
`default_nettype wire

//--- logic/power_seq_pkg.sv
// power sequencer package: modes, sequence states, timing, carrier structs
// assumes a 25 MHz ref_clk standing in for the timer oscillator
package power_seq_pkg;

  localparam int CLK_HZ = 25000000;
  // start-up budget from trigger to boot, in microseconds
  localparam int STARTUP_US = 2500;
  localparam int STARTUP_CYCLES = (STARTUP_US * (CLK_HZ / 1000000));
  // digital regulator settle share of start-up, in microseconds
  localparam int DIG_SETTLE_US = 500;
  localparam int DIG_SETTLE_CYCLES = (DIG_SETTLE_US * (CLK_HZ / 1000000));
  // analog regulator settle share, in microseconds
  localparam int ANA_SETTLE_US = 2000;
  localparam int ANA_SETTLE_CYCLES = (ANA_SETTLE_US * (CLK_HZ / 1000000));
  // least wake pin low time, in microseconds
  localparam int WAKE_LOW_US = 100;
  localparam int WAKE_LOW_CYCLES = (WAKE_LOW_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 17;
  localparam int RET_WORDS = 5;
  localparam int RET_W = 32;
  localparam int ANA_PERIPH = 8;
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_DEEP_SLEEP = 2'h2;
  localparam logic [1:0] REQ_DEEP_PD = 2'h3;
  localparam logic [RET_W-1:0] RET_RESET = 32'h0;
  localparam logic [ANA_PERIPH-1:0] PD_RESET = 8'hFF;

  typedef enum logic [2:0] {
    BATTERY_OFF, SEQ_DIGITAL, SEQ_ANALOG, SEQ_BOOT, ACTIVE, SLEEP, DEEP_SLEEP, DEEP_PD
  } mode_t;

  // power control register contents written by the core
  typedef struct packed {
    logic [1:0] modeReq;      // entry request, one of REQ_*
    logic autoSwitchOff;      // disables automatic source selection
    logic batteryOverride;    // forces the battery switch open
    logic brownoutEnable;
    logic fieldWakeEnable;
    logic wakePinEnable;
  } power_ctrl_t;

  // analog monitor comparator levels, plus oscillator stable and flash ready status
  typedef struct packed {
    logic batteryAbove;       // battery rail above 1.72 V
    logic fieldAbove;         // field rail present and higher
    logic fieldPresent;       // RF field detected
    logic alwaysOnLow;        // always-on rail below 1.8 V
    logic systemOscStable;
    logic flashReady;
  } monitor_t;

  // wake causes from on-chip logic
  typedef struct packed {
    logic timerPreset;
    logic watchdog;
    logic startLogic;
  } wake_src_t;

  // power switch and regulator controls
  typedef struct packed {
    logic batteryPowerSwitch;
    logic fieldPowerSwitch;
    logic digitalRegulator;
    logic analogRegulator;
    logic comparatorEnable;
    logic alwaysOnDomain;
  } power_out_t;

endpackage

//--- logic/sync_two_ff.sv
// two flip-flop level synchroniser with synchronous reset value
// assumes a level input asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] resetValue,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // -----------------------------
  // next state
  // -----------------------------
  always_comb begin
    state_next.first = asyncIn;
    state_next.second = state_reg.first;
  end

  // reset loads a fixed value from a tie-off constant input
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= {resetValue, resetValue};
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.second;
endmodule // sync_two_ff
`default_nettype wire

//--- verification/trigger_pin_model.sv
// board-side model of the reset button and the wake pin
// assumes both pins have board pull-ups, so a released pin reads high
`timescale 1ns/100ps
`default_nettype none
module trigger_pin_model (
  input wire logic ref_clk,
  input wire logic holdReset,
  input wire logic wakeGo,
  input wire logic [15:0] wakeLen,
  output logic external_reset_pin,
  output logic wake_pin
);
  logic pinReg = 1'h1;
  logic [15:0] lowCount = 16'h0;
  // button pressed drives low, released reads the pull-up
  always @(posedge ref_clk) begin
    pinReg <= ~holdReset;
  end
  // wake pin held low for the commanded span only
  always @(posedge ref_clk) begin
    if (wakeGo) begin
      lowCount <= wakeLen;
    end else if (lowCount != 16'h0) begin
      lowCount <= lowCount - 16'h1;
    end
  end
  assign external_reset_pin = pinReg;
  assign wake_pin = (lowCount == 16'h0);
endmodule // trigger_pin_model
`default_nettype wire

//--- verification/tb_power_source_and_mode_sequencer.sv
// self-checking bench for the power source and mode sequencer
// assumes the package start-up counts are left at their defaults
`timescale 1ns/100ps
`default_nettype none
module tb_power_source_and_mode_sequencer;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic holdReset = 1'h0;
  logic wakeGo = 1'h0;
  logic [15:0] wakeLen = 16'h0;
  logic external_reset_pin;
  logic wake_pin;
  power_seq_pkg::monitor_t mon = '0;
  power_seq_pkg::wake_src_t src = '0;
  power_seq_pkg::power_ctrl_t ctl = '0;
  logic ctlWr = 1'h0;
  logic offReq = 1'h0;
  logic pdWr = 1'h0;
  logic retWr = 1'h0;
  logic flagClr = 1'h0;
  logic [7:0] pdIn = 8'h0;
  logic [2:0] retIdx = 3'h0;
  logic [31:0] retData = 32'h0;
  power_seq_pkg::power_out_t pwr;
  power_seq_pkg::mode_t mode;
  logic dpdFlag, sleepFlag, sysPor, boot, bodIrq, oscEn;
  logic [7:0] pdOut;
  logic [31:0] retOut;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;

  // clock and cycle count
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;

  trigger_pin_model pins (.ref_clk(ref_clk), .holdReset(holdReset), .wakeGo(wakeGo),
    .wakeLen(wakeLen), .external_reset_pin(external_reset_pin), .wake_pin(wake_pin));

  power_source_and_mode_sequencer dut (.ref_clk(ref_clk), .reset(reset),
    .external_reset_pin(external_reset_pin), .wake_pin(wake_pin), .monitorIn(mon),
    .wakeSrc(src), .powerCtrl(ctl), .powerCtrlWrite(ctlWr), .offRequest(offReq),
    .analogPowerDownIn(pdIn), .analogPowerDownWrite(pdWr), .retentionWrite(retWr),
    .retentionIndex(retIdx), .retentionData(retData), .flagClear(flagClr),
    .powerOut(pwr), .mode(mode), .deep_powerdown_flag(dpdFlag), .sleepFlag(sleepFlag),
    .systemPowerOnReset(sysPor), .bootEnable(boot), .brownoutIrq(bodIrq),
    .timerOscEnable(oscEn), .analogPowerDown(pdOut), .retentionOut(retOut));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic waitMode(input power_seq_pkg::mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(mode, m, "mode not reached");
  endtask
  task automatic ctrl(input logic [1:0] req, input logic [4:0] bits);
    @(posedge ref_clk);
    ctl <= {req, bits};
    ctlWr <= 1'h1;
    @(posedge ref_clk);
    ctlWr <= 1'h0;
  endtask
  task automatic clearFlags;
    @(posedge ref_clk);
    flagClr <= 1'h1;
    @(posedge ref_clk);
    flagClr <= 1'h0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    tick(1);
    chk(mode, power_seq_pkg::BATTERY_OFF, "reset mode");
    chk(pwr, 6'h02, "reset outputs");
    chk(pdOut, 8'hFF, "gate reset");
    chk(oscEn, 1'h1, "timer osc off");
    @(posedge ref_clk);
    mon.batteryAbove <= 1'h1;
    tick(20);
    chk(pwr.batteryPowerSwitch, 1'h0, "switch closed untriggered");
  endtask
  task automatic t_powerUp;
    @(posedge ref_clk);
    holdReset <= 1'h1;
    tick(4);
    @(posedge ref_clk);
    holdReset <= 1'h0;
    t0 = cyc;
    waitMode(power_seq_pkg::SEQ_DIGITAL, 20);
    chk(pwr.batteryPowerSwitch, 1'h1, "battery not used");
    chk({pwr.digitalRegulator, pwr.analogRegulator}, 2'h2, "first state");
    waitMode(power_seq_pkg::SEQ_ANALOG, power_seq_pkg::DIG_SETTLE_CYCLES + 10);
    chk(pwr.analogRegulator, 1'h1, "analog regulator off");
    tick(10);
    chk(sysPor, 1'h0, "por before osc stable");
    @(posedge ref_clk);
    mon.systemOscStable <= 1'h1;
    tick(6);
    chk(sysPor, 1'h1, "por missing");
    waitMode(power_seq_pkg::SEQ_BOOT, power_seq_pkg::STARTUP_CYCLES);
    tick(50);
    chk(boot, 1'h0, "boot before flash");
    @(posedge ref_clk);
    mon.flashReady <= 1'h1;
    waitMode(power_seq_pkg::ACTIVE, power_seq_pkg::STARTUP_CYCLES);
    chk(cyc - t0 <= power_seq_pkg::STARTUP_CYCLES + 100, 1'h1, "start-up too long");
    chk(cyc - t0 >= power_seq_pkg::STARTUP_CYCLES - 100, 1'h1, "start-up too short");
    chk({boot, dpdFlag, sleepFlag, pwr.digitalRegulator, pwr.analogRegulator}, 5'h13,
      "active encoding");
  endtask
  task automatic t_source;
    @(posedge ref_clk);
    mon.fieldPresent <= 1'h1;
    tick(4);
    chk({pwr.batteryPowerSwitch, pwr.fieldPowerSwitch}, 2'h3, "field switch");
    @(posedge ref_clk);
    mon.batteryAbove <= 1'h0;
    mon.fieldAbove <= 1'h1;
    tick(4);
    chk({pwr.batteryPowerSwitch, pwr.fieldPowerSwitch}, 2'h1, "no switchover");
    chk(mode, power_seq_pkg::ACTIVE, "mode lost on switchover");
    @(posedge ref_clk);
    mon.batteryAbove <= 1'h1;
    tick(4);
    chk(pwr.batteryPowerSwitch, 1'h1, "no switch back");
    ctrl(power_seq_pkg::REQ_NONE, 5'h08);
    tick(3);
    chk({pwr.batteryPowerSwitch, pwr.fieldPowerSwitch}, 2'h1, "override kept battery");
    chk(mode, power_seq_pkg::ACTIVE, "mode lost on override");
    ctrl(power_seq_pkg::REQ_NONE, 5'h00);
    tick(3);
    chk(pwr.batteryPowerSwitch, 1'h1, "override not released");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      retWr <= 1'h1;
      retIdx <= i[2:0];
      retData <= 32'hC0DE0000 + i;
    end
    @(posedge ref_clk);
    retWr <= 1'h0;
    pdWr <= 1'h1;
    pdIn <= 8'h5A;
    @(posedge ref_clk);
    pdWr <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      retIdx <= i[2:0];
      tick(2);
      chk(retOut, (i < 5) ? 32'hC0DE0000 + i : 32'h0, "retention");
      @(posedge ref_clk);
    end
    chk(pdOut, 8'h5A, "analog gates");
  endtask
  task automatic t_brownout;
    @(posedge ref_clk);
    mon.alwaysOnLow <= 1'h1;
    tick(5);
    chk(bodIrq, 1'h0, "brownout while disabled");
    ctrl(power_seq_pkg::REQ_NONE, 5'h04);
    tick(5);
    chk(bodIrq, 1'h1, "brownout missing");
    clearFlags();
    tick(2);
    chk(bodIrq, 1'h1, "brownout lost while low");
    @(posedge ref_clk);
    mon.alwaysOnLow <= 1'h0;
    tick(4);
    clearFlags();
    tick(2);
    chk(bodIrq, 1'h0, "brownout not cleared");
  endtask
  task automatic t_sleep(input logic [1:0] req, input power_seq_pkg::mode_t m,
    input logic [2:0] w);
    ctrl(req, 5'h04);
    waitMode(m, 10);
    chk({dpdFlag, sleepFlag, pwr.digitalRegulator, pwr.analogRegulator}, 4'h7,
      "sleep encoding");
    @(posedge ref_clk);
    src <= w;
    waitMode(power_seq_pkg::ACTIVE, 10);
    @(posedge ref_clk);
    src <= '0;
    clearFlags();
  endtask
  task automatic t_deepPd;
    ctrl(power_seq_pkg::REQ_DEEP_PD, 5'h05);
    waitMode(power_seq_pkg::DEEP_PD, 10);
    chk({dpdFlag, sleepFlag, pwr.digitalRegulator, pwr.analogRegulator}, 4'h8,
      "deep power-down encoding");
    @(posedge ref_clk);
    src <= 3'h3;
    tick(20);
    chk(mode, power_seq_pkg::DEEP_PD, "woken by sleep-only source");
    @(posedge ref_clk);
    src <= '0;
    wakeGo <= 1'h1;
    wakeLen <= 16'(power_seq_pkg::WAKE_LOW_CYCLES / 2);
    @(posedge ref_clk);
    wakeGo <= 1'h0;
    tick(power_seq_pkg::WAKE_LOW_CYCLES);
    chk(mode, power_seq_pkg::DEEP_PD, "woken by short pulse");
    @(posedge ref_clk);
    retIdx <= 3'h2;
    tick(2);
    chk(retOut, 32'hC0DE0002, "retention lost");
    @(posedge ref_clk);
    wakeGo <= 1'h1;
    wakeLen <= 16'(power_seq_pkg::WAKE_LOW_CYCLES + 10);
    @(posedge ref_clk);
    wakeGo <= 1'h0;
    waitMode(power_seq_pkg::SEQ_DIGITAL, power_seq_pkg::WAKE_LOW_CYCLES + 50);
  endtask
  task automatic t_off;
    ctrl(power_seq_pkg::REQ_NONE, 5'h10);
    tick(5);
    chk({pwr.batteryPowerSwitch, pwr.comparatorEnable}, 2'h2, "auto switch off");
    ctrl(power_seq_pkg::REQ_NONE, 5'h00);
    @(posedge ref_clk);
    offReq <= 1'h1;
    tick(10);
    chk(pwr.batteryPowerSwitch, 1'h1, "off while field present");
    @(posedge ref_clk);
    mon.fieldPresent <= 1'h0;
    mon.fieldAbove <= 1'h0;
    waitMode(power_seq_pkg::BATTERY_OFF, 20);
    chk(pwr.batteryPowerSwitch, 1'h0, "battery switch stays");
  endtask

  task automatic results;
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog on a hung sequence
  initial begin
    #4000000;
    failures++;
    results();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'h0;
    t_reset();
    t_powerUp();
    t_source();
    t_regs();
    t_brownout();
    t_sleep(power_seq_pkg::REQ_SLEEP, power_seq_pkg::SLEEP, 3'h1);
    t_sleep(power_seq_pkg::REQ_DEEP_SLEEP, power_seq_pkg::DEEP_SLEEP, 3'h2);
    t_sleep(power_seq_pkg::REQ_DEEP_SLEEP, power_seq_pkg::DEEP_SLEEP, 3'h4);
    t_deepPd();
    t_off();
    results();
  end
endmodule // tb_power_source_and_mode_sequencer
`default_nettype wire
